//--- rtl/cid_core.sv
/*
 Instruction decode and execute block with an AHB-Lite register slave.
 Software loads an instruction, operands and core registers, then starts it;
 the block stays busy for the instruction's cycle count and commits results.
 Assumes a single-master bus with only word transfers.
*/
`include "cid_params.svh"
module cid_core (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // Core pins
  input  wire logic        irq_line_i,
  output logic             busy_o,
  output logic             done_o
);
  cid_pkg::cid_state_t st;
  cid_pkg::cid_state_t nxt;
  cid_dec_if           dec ();
  logic                rdy_r;
  logic                acc_ph;
  logic                commit;
  logic [7:0]          m_val;
  logic [15:0]         ea;
  logic [15:0]         pc_next;
  logic [8:0]          diff;
  logic [8:0]          sum;
  logic [4:0]          hsum;
  logic                cin;
  logic                cond;
  logic [7:0]          res;
  logic [7:0]          bmask;
  logic                tbit;
  logic [3:0]          busy_len;

  cid_decoder i_cid_decoder (
    .d (dec)
  );

  assign dec.opcode = st.op;

  // Outputs straight from flops, except hresp, which is tied low
  assign hrdata_o    = st.hrdata;
  assign hreadyout_o = rdy_r;
  assign hresp_o     = 1'b0;
  assign busy_o      = (st.fsm == cid_pkg::ST_EXEC);
  assign done_o      = st.done;

  assign acc_ph  = hsel_i && htrans_i[1] && hready_i && (hsize_i == `CID_HSIZE_W);
  assign commit  = (st.fsm == cid_pkg::ST_EXEC) && (st.cnt == 4'h1);
  assign m_val   = (dec.mode == cid_pkg::M_IMM) ? st.b1 : st.opnd;
  assign cin     = st.ccr[`CID_CCR_C];
  assign pc_next = st.pc + {14'h0000, dec.len};
  assign bmask   = 8'h01 << st.op[3:1];
  assign tbit    = |(st.opnd & bmask);

  // Effective address per mode
  always_comb begin
    unique case (dec.mode)
      cid_pkg::M_DIR: ea = {8'h00, st.b1};
      cid_pkg::M_EXT: ea = {st.b1, st.b2};
      cid_pkg::M_IX:  ea = {8'h00, st.idx};
      cid_pkg::M_IX1: ea = {8'h00, st.idx} + {8'h00, st.b1};
      cid_pkg::M_IX2: ea = {st.b1, st.b2} + {8'h00, st.idx};
      default:        ea = pc_next;
    endcase
  end

  // Adder and subtracter shared by the arithmetic opcodes
  always_comb begin
    logic [7:0] lhs;
    logic       ci;
    lhs  = (st.op[3:0] == 4'h3) ? st.idx : st.acc;
    ci   = (st.op[3:0] == 4'h2 || st.op[3:0] == 4'h9) ? cin : 1'b0;
    diff = {1'b0, lhs} - {1'b0, m_val} - {8'h00, ci};
    sum  = {1'b0, st.acc} + {1'b0, m_val} + {8'h00, ci};
    hsum = {1'b0, st.acc[3:0]} + {1'b0, m_val[3:0]} + {4'h0, ci};
  end

  // Branch condition by low nibble
  always_comb begin
    unique case (st.op[3:0])
      4'h0: cond = 1'b1;
      4'h1: cond = 1'b0;
      4'h2: cond = !(st.ccr[`CID_CCR_C] || st.ccr[`CID_CCR_Z]);
      4'h3: cond = st.ccr[`CID_CCR_C] || st.ccr[`CID_CCR_Z];
      4'h4: cond = !st.ccr[`CID_CCR_C];
      4'h5: cond = st.ccr[`CID_CCR_C];
      4'h6: cond = !st.ccr[`CID_CCR_Z];
      4'h7: cond = st.ccr[`CID_CCR_Z];
      4'h8: cond = !st.ccr[`CID_CCR_H];
      4'h9: cond = st.ccr[`CID_CCR_H];
      4'hA: cond = !st.ccr[`CID_CCR_N];
      4'hB: cond = st.ccr[`CID_CCR_N];
      4'hC: cond = !st.ccr[`CID_CCR_I];
      4'hD: cond = st.ccr[`CID_CCR_I];
      4'hE: cond = !irq_line_i;
      default: cond = irq_line_i;
    endcase
  end

  // Next state: bus writes, execution, read data
  always_comb begin
    nxt      = st;
    nxt.dsel = acc_ph;
    nxt.dwr  = hwrite_i;
    nxt.daddr = haddr_i[7:0];
    res      = 8'h00;
    // Data phase of a write
    if (st.dsel && st.dwr) begin
      if (st.daddr == `CID_REG_STATUS && hwdata_i[`CID_ST_DONE]) begin
        nxt.done = 1'b0;
      end
      if (st.fsm == cid_pkg::ST_IDLE) begin
        unique case (st.daddr)
          `CID_REG_CTRL: begin
            if (hwdata_i[0]) begin
              nxt.fsm     = cid_pkg::ST_EXEC;
              nxt.cnt     = dec.cycles;
              nxt.taken   = 1'b0;
              nxt.illegal = 1'b0;
            end
          end
          `CID_REG_INSTR: begin
            nxt.op = hwdata_i[7:0];
            nxt.b1 = hwdata_i[15:8];
            nxt.b2 = hwdata_i[23:16];
          end
          `CID_REG_ACC:   nxt.acc  = hwdata_i[7:0];
          `CID_REG_INDEX: nxt.idx  = hwdata_i[7:0];
          `CID_REG_CCR:   nxt.ccr  = hwdata_i[4:0];
          `CID_REG_OPND:  nxt.opnd = hwdata_i[7:0];
          `CID_REG_PC:    nxt.pc   = hwdata_i[15:0];
          default: ;
        endcase
      end
    end
    // Count down the instruction's cycles
    if (st.fsm == cid_pkg::ST_EXEC && !commit) begin
      nxt.cnt = st.cnt - 4'h1;
    end
    // Commit in the last busy cycle; done set wins over clear
    if (commit) begin
      nxt.fsm  = cid_pkg::ST_IDLE;
      nxt.done = 1'b1;
      nxt.pc   = pc_next;
      unique case (dec.cls)
        cid_pkg::CL_PRODUCT: begin
          {nxt.idx, nxt.acc} = st.idx * st.acc;
          nxt.ccr[`CID_CCR_H] = 1'b0;
          nxt.ccr[`CID_CCR_C] = 1'b0;
        end
        cid_pkg::CL_BRANCH: begin
          nxt.taken = cond;
          if (cond) begin
            nxt.pc = cid_pkg::rel_target(st.pc, dec.len, st.b1);
          end
        end
        cid_pkg::CL_CALL_REL: begin
          nxt.taken = 1'b1;
          nxt.ret   = pc_next;
          nxt.pc    = cid_pkg::rel_target(st.pc, dec.len, st.b1);
        end
        cid_pkg::CL_BITTEST: begin
          nxt.ccr[`CID_CCR_C] = tbit;
          nxt.taken = tbit ^ st.op[0];
          if (tbit ^ st.op[0]) begin
            nxt.pc = cid_pkg::rel_target(st.pc, dec.len, st.b2);
          end
        end
        cid_pkg::CL_BITMOD: begin
          nxt.memout = st.op[0] ? (st.opnd & ~bmask) : (st.opnd | bmask);
        end
        cid_pkg::CL_REGMEM: begin
          unique case (st.op[3:0])
            4'h0, 4'h2: begin
              res = diff[7:0];
              nxt.acc = res;
              nxt.ccr[`CID_CCR_C] = diff[8];
            end
            4'h1, 4'h3: begin
              res = diff[7:0];
              nxt.ccr[`CID_CCR_C] = diff[8];
            end
            4'h4: begin res = st.acc & m_val; nxt.acc = res; end
            4'h5: res = st.acc & m_val;
            4'h6: begin res = m_val; nxt.acc = res; end
            4'h7: begin res = st.acc; nxt.memout = res; end
            4'h8: begin res = st.acc ^ m_val; nxt.acc = res; end
            4'hA: begin res = st.acc | m_val; nxt.acc = res; end
            4'h9, 4'hB: begin
              res = sum[7:0];
              nxt.acc = res;
              nxt.ccr[`CID_CCR_C] = sum[8];
              nxt.ccr[`CID_CCR_H] = hsum[4];
            end
            4'hC: nxt.pc = ea;
            4'hD: begin nxt.ret = pc_next; nxt.pc = ea; end
            4'hE: begin res = m_val; nxt.idx = res; end
            default: begin res = st.idx; nxt.memout = res; end
          endcase
          if (st.op[3:0] != 4'hC && st.op[3:0] != 4'hD) begin
            nxt.ccr[`CID_CCR_N] = res[7];
            nxt.ccr[`CID_CCR_Z] = (res == 8'h00);
          end
        end
        default: begin
          nxt.illegal = 1'b1;
          nxt.pc      = st.pc;
        end
      endcase
    end
    // Read data from the updated state for back-to-back accesses, except INFO, decoded from the registered opcode
    if (acc_ph && !hwrite_i) begin
      unique case (haddr_i[7:0])
        `CID_REG_STATUS: nxt.hrdata = {28'h0000000, nxt.illegal, nxt.taken, nxt.done,
                                       nxt.fsm == cid_pkg::ST_EXEC};
        `CID_REG_INSTR:  nxt.hrdata = {8'h00, nxt.b2, nxt.b1, nxt.op};
        `CID_REG_ACC:    nxt.hrdata = {24'h000000, nxt.acc};
        `CID_REG_INDEX:  nxt.hrdata = {24'h000000, nxt.idx};
        `CID_REG_CCR:    nxt.hrdata = {27'h0000000, nxt.ccr};
        `CID_REG_OPND:   nxt.hrdata = {24'h000000, nxt.opnd};
        `CID_REG_INFO:   nxt.hrdata = {20'h00000, dec.cycles, 6'h00, dec.len};
        `CID_REG_PC:     nxt.hrdata = {16'h0000, nxt.pc};
        `CID_REG_RET:    nxt.hrdata = {16'h0000, nxt.ret};
        `CID_REG_MEMOUT: nxt.hrdata = {24'h000000, nxt.memout};
        default:         nxt.hrdata = 32'h00000000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st     <= '0;
      st.ccr <= `CID_CCR_RST;
      rdy_r  <= 1'b0;
    end else begin
      st    <= nxt;
      rdy_r <= 1'b1;
    end
  end

  // Busy cycle counter watched by the busy length check
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || st.fsm == cid_pkg::ST_IDLE) begin
      busy_len <= 4'h0;
    end else begin
      busy_len <= busy_len + 4'h1;
    end
  end

  a_busy_length: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    commit |-> (busy_len + 4'h1 == dec.cycles))
    else $error("busy time differs from cycle count");

  a_product_value: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (commit && dec.cls == cid_pkg::CL_PRODUCT) |=>
      ({st.idx, st.acc} == $past(st.idx) * $past(st.acc)) && !busy_o)
    else $error("product wrong");

  a_product_flags: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (commit && dec.cls == cid_pkg::CL_PRODUCT) |=> !st.ccr[`CID_CCR_H] &&
      !st.ccr[`CID_CCR_C] && (st.ccr[3:1] == $past(st.ccr[3:1])))
    else $error("product flags wrong");

  a_compare_nowrite: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (commit && dec.cls == cid_pkg::CL_REGMEM && st.op[1:0] == 2'h1 &&
     st.op[3:2] == 2'h0) |=> $stable(st.acc) && $stable(st.idx))
    else $error("compare wrote a register");

  a_xor_write: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (commit && dec.cls == cid_pkg::CL_REGMEM && st.op[3:0] == 4'h8) |=>
      st.acc == ($past(st.acc) ^ $past(m_val)))
    else $error("xor result wrong");

  a_irq_branch: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (commit && st.op == 8'h2E) |=> st.taken == !$past(irq_line_i))
    else $error("line low branch wrong");

  a_carry_branch: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (commit && st.op == 8'h25) |=> st.taken == $past(st.ccr[`CID_CCR_C]))
    else $error("carry set branch wrong");

  a_branch_timing: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (dec.cls == cid_pkg::CL_BRANCH) |-> dec.len == 2'h2 && dec.cycles == 4'h3)
    else $error("branch length or timing wrong");

  a_bittest_carry: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (commit && dec.cls == cid_pkg::CL_BITTEST) |=> st.ccr[`CID_CCR_C] ==
      $past(tbit) && st.taken == ($past(tbit) ^ $past(st.op[0])))
    else $error("bit test wrong");

  a_bitmod_single: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (commit && dec.cls == cid_pkg::CL_BITMOD) |=>
      ((st.memout ^ $past(st.opnd)) & ~$past(bmask)) == 8'h00)
    else $error("other bits disturbed");

  a_call_rel_return: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (commit && dec.cls == cid_pkg::CL_CALL_REL) |=> st.ret == $past(st.pc) + 16'h0002)
    else $error("return address wrong");

  a_ext_length: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (dec.mode == cid_pkg::M_EXT) |-> dec.len == 2'h3)
    else $error("extended length wrong");
endmodule

//--- rtl/cid_params.svh
/*
 Offsets, field positions and cycle counts of the instruction decode block.
 Assumes a 32-bit AHB-Lite slave with word-aligned registers.
*/
`ifndef CID_PARAMS_SVH
`define CID_PARAMS_SVH
// Register byte offsets
`define CID_REG_CTRL   8'h00
`define CID_REG_STATUS 8'h04
`define CID_REG_INSTR  8'h08
`define CID_REG_ACC    8'h0C
`define CID_REG_INDEX  8'h10
`define CID_REG_CCR    8'h14
`define CID_REG_OPND   8'h18
`define CID_REG_INFO   8'h1C
`define CID_REG_PC     8'h20
`define CID_REG_RET    8'h24
`define CID_REG_MEMOUT 8'h28
// Status bits
`define CID_ST_BUSY    0
`define CID_ST_DONE    1
`define CID_ST_TAKEN   2
`define CID_ST_ILLEGAL 3
// Condition code bits
`define CID_CCR_H 4
`define CID_CCR_I 3
`define CID_CCR_N 2
`define CID_CCR_Z 1
`define CID_CCR_C 0
`define CID_CCR_RST 5'h08
// Opcodes, cycle counts and the word transfer size
`define CID_OP_PRODUCT   8'h42
`define CID_OP_CALL_REL  8'hAD
`define CID_CYC_PRODUCT  4'hB
`define CID_CYC_BIT      4'h5
`define CID_CYC_BRANCH   4'h3
`define CID_CYC_CALL_REL 4'h6
`define CID_HSIZE_W   3'h2
`endif

//--- rtl/cid_pkg.sv
/*
 Types and shared helpers of the instruction decode block.
 Assumes the constants header is included by the users.
*/
package cid_pkg;
  typedef enum logic [2:0] {
    CL_ILLEGAL, CL_PRODUCT, CL_REGMEM, CL_BRANCH, CL_CALL_REL, CL_BITTEST, CL_BITMOD
  } cid_class_t;

  typedef enum logic [2:0] {
    M_NONE, M_IMM, M_DIR, M_EXT, M_IX, M_IX1, M_IX2
  } cid_mode_t;

  typedef enum logic {ST_IDLE, ST_EXEC} cid_fsm_t;

  typedef struct packed {
    cid_fsm_t    fsm;
    logic        done;
    logic        taken;
    logic        illegal;
    logic [7:0]  op;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  acc;
    logic [7:0]  idx;
    logic [4:0]  ccr;
    logic [7:0]  opnd;
    logic [15:0] pc;
    logic [15:0] ret;
    logic [7:0]  memout;
    logic [3:0]  cnt;
    logic        dsel;
    logic        dwr;
    logic [7:0]  daddr;
    logic [31:0] hrdata;
  } cid_state_t;

  // Relative target from the address after the instruction
  function automatic logic [15:0] rel_target(input logic [15:0] pc,
                                             input logic [1:0]  len,
                                             input logic [7:0]  disp);
    return pc + {14'h0000, len} + {{8{disp[7]}}, disp};
  endfunction
endpackage

//--- rtl/cid_dec_if.sv
/*
 Carrier between the executor and the opcode decoder.
 Assumes the decoder is purely combinational.
*/
interface cid_dec_if;
  logic [7:0]         opcode;
  cid_pkg::cid_class_t cls;
  cid_pkg::cid_mode_t  mode;
  logic [1:0]         len;
  logic [3:0]         cycles;
  modport dec (input opcode, output cls, mode, len, cycles);
  modport exe (output opcode, input cls, mode, len, cycles);
endinterface

//--- rtl/cid_decoder.sv
/*
 Opcode decoder: class, addressing mode, length and cycle count.
 Assumes the opcode is stable while the executor uses the answer.
*/
`include "cid_params.svh"
module cid_decoder (
  // Decode port
  cid_dec_if.dec d
);
  logic [3:0] hi;
  logic [3:0] lo;
  logic [3:0] base;

  assign hi = d.opcode[7:4];
  assign lo = d.opcode[3:0];

  // Classify the opcode and derive its timing
  always_comb begin
    d.cls    = cid_pkg::CL_ILLEGAL;
    d.mode   = cid_pkg::M_NONE;
    d.len    = 2'h1;
    d.cycles = 4'h1;
    base     = 4'h2;
    if (d.opcode == `CID_OP_PRODUCT) begin
      d.cls    = cid_pkg::CL_PRODUCT;
      d.cycles = `CID_CYC_PRODUCT;
    end else if (hi == 4'h0) begin
      d.cls    = cid_pkg::CL_BITTEST;
      d.len    = 2'h3;
      d.cycles = `CID_CYC_BIT;
    end else if (hi == 4'h1) begin
      d.cls    = cid_pkg::CL_BITMOD;
      d.len    = 2'h2;
      d.cycles = `CID_CYC_BIT;
    end else if (hi == 4'h2) begin
      d.cls    = cid_pkg::CL_BRANCH;
      d.len    = 2'h2;
      d.cycles = `CID_CYC_BRANCH;
    end else if (d.opcode == `CID_OP_CALL_REL) begin
      d.cls    = cid_pkg::CL_CALL_REL;
      d.len    = 2'h2;
      d.cycles = `CID_CYC_CALL_REL;
    end else if (hi >= 4'hA) begin
      // Mode, length and load timing per upper nibble
      unique case (hi)
        4'hA: begin d.mode = cid_pkg::M_IMM; d.len = 2'h2; base = 4'h2; end
        4'hB: begin d.mode = cid_pkg::M_DIR; d.len = 2'h2; base = 4'h3; end
        4'hC: begin d.mode = cid_pkg::M_EXT; d.len = 2'h3; base = 4'h4; end
        4'hD: begin d.mode = cid_pkg::M_IX2; d.len = 2'h3; base = 4'h5; end
        4'hE: begin d.mode = cid_pkg::M_IX1; d.len = 2'h2; base = 4'h4; end
        default: begin d.mode = cid_pkg::M_IX; d.len = 2'h1; base = 4'h3; end
      endcase
      // Stores one over loads, jumps one under, calls two over
      if (lo == 4'h7 || lo == 4'hF) begin
        d.cycles = base + 4'h1;
      end else if (lo == 4'hC) begin
        d.cycles = base - 4'h1;
      end else if (lo == 4'hD) begin
        d.cycles = base + 4'h2;
      end else begin
        d.cycles = base;
      end
      d.cls = cid_pkg::CL_REGMEM;
      // No immediate store or jump form
      if (hi == 4'hA && (lo == 4'h7 || lo == 4'hC || lo == 4'hF)) begin
        d.cls    = cid_pkg::CL_ILLEGAL;
        d.mode   = cid_pkg::M_NONE;
        d.len    = 2'h1;
        d.cycles = 4'h1;
      end
    end
  end
endmodule

//--- tb/cid_prog_mem.sv
/*
 Program memory model: opcode and operand bytes of one instruction per slot.
 Assumes the bench copies a slot's word into the instruction register.
*/
module cid_prog_mem (
  // Fetch port
  input  wire logic [2:0]  slot_i,
  output logic      [23:0] word_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] rom [0:7];
  // Loads in each addressing mode, then two stores
  initial begin
    rom[0] = 24'h005AA6;
    rom[1] = 24'h0040B6;
    rom[2] = 24'h1240C6;
    rom[3] = 24'h0000F6;
    rom[4] = 24'h0004E6;
    rom[5] = 24'h0104D6;
    rom[6] = 24'h0040B7;
    rom[7] = 24'h1240C7;
  end
  // Bytes appear as soon as the slot changes
  assign word_o = rom[slot_i];
endmodule

//--- tb/cid_core_test.sv
/*
 Self-checking bench of the instruction decode block, driven over AHB-Lite.
 Assumes zero-wait-state answers are possible but waits on hreadyout anyway.
*/
module cid_core_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys_i;
  logic        srst_i;
  logic        hsel;
  logic        hwrite;
  logic        irq_line;
  logic        hreadyout;
  logic        hresp;
  logic        busy;
  logic        done;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [2:0]  slot;
  logic [23:0] pm_word;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  int          err_count;
  int          tests_run;

  cid_core i_cid_core (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .hrdata_o(hrdata), .irq_line_i(irq_line), .busy_o(busy),
    .done_o(done));
  cid_prog_mem i_cid_prog_mem (.slot_i(slot), .word_o(pm_word));

  // Clock at 200 MHz
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // Counts comparisons and reports mismatches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_of_test;
    $display("compares=%0d mismatches=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Bounded wait for hready high at a rising edge
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      err_count++;
      end_of_test;
    end
  endtask

  // Single word write: address phase, then data phase
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b1;
    hsize <= 3'h2;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  // Single word read, data taken at the closing edge
  task automatic rdr(input logic [31:0] a);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    wait_rdy();
    rd = hrdata;
  endtask

  // Load an instruction, start it and count busy cycles
  task automatic run(input logic [23:0] ins, input logic [3:0] cyc);
    int n;
    n = 0;
    wr(32'h08, {8'h00, ins});
    wr(32'h00, 32'h1);
    #1;
    while (busy === 1'b1 && n < 40) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk(n, {28'h0, cyc});
    chk({31'h0, done}, 32'h1);
    if (n >= 40) end_of_test;
    @(posedge clk_sys_i);
  endtask

  // Register operation with accumulator, index and flags checked
  task automatic alu(input logic [7:0] a, input logic [7:0] x, input logic [23:0] ins,
                     input logic [3:0] cyc, input logic [7:0] ea, input logic [7:0] ec);
    wr(32'h0C, {24'h0, a});
    wr(32'h10, {24'h0, x});
    wr(32'h14, 32'h0);
    run(ins, cyc);
    rdr(32'h0C);
    chk(rd, {24'h0, ea});
    rdr(32'h10);
    chk(rd, {24'h0, x});
    rdr(32'h14);
    chk(rd, {24'h0, ec});
  endtask

  // Reset flags and unmapped read
  task automatic t_reset;
    chk({30'h0, hresp, busy}, 32'h0);
    rdr(32'h04);
    chk(rd, 32'h0);
    rdr(32'h14);
    chk(rd, 32'h08);
    rdr(32'h3C);
    chk(rd, 32'h0);
    $display("test reset end");
  endtask

  // Unsigned product split across index and accumulator
  task automatic t_product;
    wr(32'h0C, 32'hC8);
    wr(32'h10, 32'h0F);
    wr(32'h14, 32'h1F);
    run(24'h000042, 4'hB);
    rdr(32'h10);
    chk(rd, 32'h0B);
    rdr(32'h0C);
    chk(rd, 32'hB8);
    rdr(32'h14);
    chk(rd, 32'h0E);
    $display("test product end");
  endtask

  // Every addressing mode of load, and stores in direct and extended modes
  task automatic t_modes;
    logic [3:0] cy [8];
    logic [1:0] ln [8];
    cy = '{4'h2, 4'h3, 4'h4, 4'h3, 4'h4, 4'h5, 4'h4, 4'h5};
    ln = '{2'h2, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3, 2'h2, 2'h3};
    wr(32'h18, 32'h5A);
    for (int i = 0; i < 8; i++) begin
      slot = i[2:0];
      #1;
      wr(32'h0C, 32'h30 + i);
      run(pm_word, cy[i]);
      rdr(32'h1C);
      chk(rd, {20'h0, cy[i], 6'h0, ln[i]});
      rdr(32'h0C);
      chk(rd, (i < 6) ? 32'h5A : 32'h30 + i);
      if (i >= 6) begin
        rdr(32'h28);
        chk(rd, 32'h30 + i);
      end
    end
    $display("test modes end");
  endtask

  // Logic, compare, exclusive-or and add operations
  task automatic t_alu;
    wr(32'h18, 32'h3C);
    alu(8'h0F, 8'h00, 24'h00FFA8, 4'h2, 8'hF0, 8'h04);
    alu(8'h3C, 8'h00, 24'h0004E8, 4'h4, 8'h00, 8'h02);
    alu(8'hF0, 8'h00, 24'h000FA5, 4'h2, 8'hF0, 8'h02);
    alu(8'h3C, 8'h00, 24'h0000F5, 4'h3, 8'h3C, 8'h00);
    alu(8'h10, 8'h00, 24'h0020A1, 4'h2, 8'h10, 8'h05);
    alu(8'h00, 8'h30, 24'h0030A3, 4'h2, 8'h00, 8'h02);
    alu(8'h0F, 8'h00, 24'h0001AB, 4'h2, 8'h10, 8'h10);
    $display("test alu end");
  endtask

  // Twelve branch conditions, five of them both taken and not taken: opcode, flags, pin, outcome
  task automatic t_branch;
    logic [23:0] br [17];
    br = '{24'h200001, 24'h210000, 24'h220001, 24'h220100, 24'h230201, 24'h230000,
           24'h240001, 24'h240100, 24'h250101, 24'h281000, 24'h291001, 24'h2C0800,
           24'h2D0801, 24'h2E0001, 24'h2E0010, 24'h2F0000, 24'h2F0011};
    foreach (br[i]) begin
      irq_line <= br[i][4];
      wr(32'h14, {24'h0, br[i][15:8]});
      wr(32'h20, 32'h0100);
      run({8'h00, 8'h10, br[i][23:16]}, 4'h3);
      rdr(32'h20);
      chk(rd, br[i][0] ? 32'h0112 : 32'h0102);
    end
    irq_line <= 1'b0;
    $display("test branch end");
  endtask

  // Bit test jumps, bit set and clear, relative and extended calls, illegal opcode
  task automatic t_bits;
    wr(32'h18, 32'h80);
    wr(32'h20, 32'h0100);
    run(24'h20400E, 4'h5);
    rdr(32'h20);
    chk(rd, 32'h0123);
    wr(32'h20, 32'h0100);
    run(24'h20400F, 4'h5);
    rdr(32'h20);
    chk(rd, 32'h0103);
    wr(32'h20, 32'h0100);
    run(24'h204001, 4'h5);
    rdr(32'h20);
    chk(rd, 32'h0123);
    wr(32'h18, 32'h00);
    run(24'h00401E, 4'h5);
    rdr(32'h28);
    chk(rd, 32'h80);
    wr(32'h18, 32'hFF);
    run(24'h004011, 4'h5);
    rdr(32'h28);
    chk(rd, 32'hFE);
    wr(32'h20, 32'h0100);
    run(24'h00F0AD, 4'h6);
    rdr(32'h20);
    chk(rd, 32'h00F2);
    rdr(32'h24);
    chk(rd, 32'h0102);
    wr(32'h20, 32'h0100);
    run(24'h4012CD, 4'h6);
    rdr(32'h20);
    chk(rd, 32'h1240);
    rdr(32'h24);
    chk(rd, 32'h0103);
    run(24'h0000A7, 4'h1);
    rdr(32'h20);
    chk(rd, 32'h1240);
    rdr(32'h04);
    chk(rd, 32'h0A);
    wr(32'h04, 32'h2);
    rdr(32'h04);
    chk(rd, 32'h08);
    $display("test bits end");
  endtask

  // Main sequence
  initial begin
    err_count = 0;
    tests_run = 0;
    srst_i = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    irq_line = 1'b0;
    slot = 3'h0;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_reset();
    t_product();
    t_modes();
    t_alu();
    t_branch();
    t_bits();
    end_of_test;
  end
endmodule
